/* link_gate_ctrl.sv */
// Function
// [R1] Link drives all lanes zero for idle
// [R2] PHY grounds termination when doubly terminated
// [R3] All-zero payload words still pass as data
// [R4] Gated forwarded clock held differential low
// [R5] Lanes stay idle throughout gated state
// [R6] Preamble and postamble frame each gated interval
// [R7] Lengths are whole multiples of word width
// [R8] Serialization ratio limited to powers of two
// [R9] Lengths selectable as 4, 8, 16, 32 UI
// [R10] Request rises one word before clock stops
// [R11] Request falls one word before clock restarts
// [R12] Amble and gated words carry idle data
// [R13] Multi-word ambles padded with idle words
// [R14] Gated time under smaller occupancy limit
// [R15] PHY samples request, counts gated words
// [R16] Link counts and wakes before limit
`timescale 1ns/1ps
`default_nettype none
`include "clock_gate_map.svh"

module link_gate_ctrl (
   input wire logic clk,
   input wire logic rst_n,
   clock_gate_if.link lnk,
   input wire logic [4:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest
);
   localparam logic [7:0] WAKE_AT = 8'(`GATE_LIMIT - `WAKE_MARGIN);

   clock_gate_pkg::linkState_t st_r, st_nxt;
   logic [7:0] cnt_r, cnt_nxt;
   logic [3:0] pay_r, pay_nxt;
   logic [6:0] ctrl_r, ctrl_nxt;
   clock_gate_pkg::word_t data_r, data_nxt;
   logic pend_r, pend_nxt;
   logic ack_r, ack_nxt;
   logic [31:0] rd_r, rd_nxt;
   logic dataAddr, stall, doWrite;
   logic [3:0] preWords, postWords, payWords;

   ////////////////////////////////////////////////////////////////////
   // Amble lengths in words

   function automatic logic [3:0] ambleWords(input logic [1:0] sel);
      logic [7:0] ui;
      ui = 8'(`AMBLE_BASE_UI) << sel; // [R9]
      // 4 UI never spans less than one word at this ratio
      ambleWords = 4'(ui / 8'(`SER_RATIO)); // [R7]
   endfunction

   assign postWords = ambleWords(ctrl_r[`CTRL_POST_LSB +: 2]);
   assign preWords = ambleWords(ctrl_r[`CTRL_PRE_LSB +: 2]);
   assign payWords = ambleWords(ctrl_r[`CTRL_PAY_LSB +: 2]);

   ////////////////////////////////////////////////////////////////////
   // Register slave

   assign dataAddr = (address == `DATA0_OFS) || (address == `DATA1_OFS) ||
      (address == `DATA2_OFS);
   // A word still queued for the link must not be torn by a new write
   assign stall = write && dataAddr && pend_r;
   assign waitrequest = (read || write) && !ack_r;
   assign doWrite = write && ack_r;
   assign readdata = rd_r;

   always_comb
   begin
      ack_nxt = (read || write) && !ack_r && !stall;
      rd_nxt = rd_r;
      if (read && !ack_r)
      begin
         unique case (address)
            `CTRL_OFS: rd_nxt = {25'h000_0000, ctrl_r};
            `DATA0_OFS: rd_nxt = data_r[31:0];
            `DATA1_OFS: rd_nxt = data_r[63:32];
            `DATA2_OFS: rd_nxt = {24'h00_0000, data_r[71:64]};
            `STATUS_OFS: rd_nxt = {16'h0000, cnt_r, 5'h00,
               st_r != clock_gate_pkg::SEND, st_r == clock_gate_pkg::GATED, pend_r};
            default: rd_nxt = 32'h0000_0000;
         endcase
      end
      ctrl_nxt = ctrl_r;
      data_nxt = data_r;
      if (doWrite)
      begin
         unique case (address)
            `CTRL_OFS: ctrl_nxt = writedata[6:0];
            `DATA0_OFS: data_nxt[31:0] = writedata;
            `DATA1_OFS: data_nxt[63:32] = writedata;
            `DATA2_OFS: data_nxt[71:64] = writedata[7:0];
            default: ctrl_nxt = ctrl_r;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Gating sequencer

   // Only a queued payload word leaves non-zero; everything else is idle
   assign lnk.word = (st_r == clock_gate_pkg::SEND && pend_r) ? data_r : '0; // [R1] [R3] [R12]
   assign lnk.clockGateRequest = (st_r == clock_gate_pkg::ASK) ||
      (st_r == clock_gate_pkg::GATED); // [R10]

   always_comb
   begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      pay_nxt = pay_r;
      // Committing the top slice queues the word; set wins over consume
      pend_nxt = pend_r;
      if (lnk.wordStrobe && st_r == clock_gate_pkg::SEND)
         pend_nxt = 1'b0;
      if (doWrite && address == `DATA2_OFS)
         pend_nxt = 1'b1;
      if (lnk.wordStrobe)
      begin
         unique case (st_r)
            clock_gate_pkg::SEND:
            begin
               if (pay_r != 4'hF)
                  pay_nxt = pay_r + 4'h1;
               // Payload must reach its minimum before another stop
               if (ctrl_r[`CTRL_SLEEP] && !pend_r && pay_nxt >= payWords) // [R7]
               begin
                  // A one-word postamble is the request word alone
                  if (postWords == 4'h1)
                     st_nxt = clock_gate_pkg::ASK; // [R6] [R9]
                  else
                     st_nxt = clock_gate_pkg::POST; // [R6]
                  cnt_nxt = 8'h00;
               end
            end
            clock_gate_pkg::POST:
            begin
               // Longer postambles are padded with idle words
               cnt_nxt = cnt_r + 8'h01; // [R13]
               if (cnt_nxt >= 8'(postWords) - 8'h01)
                  st_nxt = clock_gate_pkg::ASK;
            end
            clock_gate_pkg::ASK:
            begin
               st_nxt = clock_gate_pkg::GATED; // [R10]
               cnt_nxt = 8'h00;
            end
            clock_gate_pkg::GATED:
            begin
               cnt_nxt = cnt_r + 8'h01; // [R16]
               // Wake early: restart lands one word after release
               if (!ctrl_r[`CTRL_SLEEP] || cnt_nxt >= WAKE_AT) // [R14] [R16]
                  st_nxt = clock_gate_pkg::WAKE; // [R11]
            end
            clock_gate_pkg::WAKE:
            begin
               st_nxt = clock_gate_pkg::PRE; // [R5]
               cnt_nxt = 8'h00;
            end
            clock_gate_pkg::PRE:
            begin
               cnt_nxt = cnt_r + 8'h01; // [R13]
               if (cnt_nxt >= 8'(preWords))
               begin
                  st_nxt = clock_gate_pkg::SEND; // [R6]
                  pay_nxt = 4'h0;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         st_r <= clock_gate_pkg::SEND;
         cnt_r <= 8'h00;
         pay_r <= 4'h0;
         ctrl_r <= `CTRL_RESET;
         data_r <= '0;
         pend_r <= 1'b0;
         ack_r <= 1'b0;
         rd_r <= 32'h0000_0000;
      end
      else
      begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         pay_r <= pay_nxt;
         ctrl_r <= ctrl_nxt;
         data_r <= data_nxt;
         pend_r <= pend_nxt;
         ack_r <= ack_nxt;
         rd_r <= rd_nxt;
      end
   end

endmodule

`default_nettype wire

/* clock_gate_map.svh */
`ifndef CLOCK_GATE_MAP_SVH
`define CLOCK_GATE_MAP_SVH

// Serializer shape: lanes 0..15 data, 16 auxiliary, 17 error_correction_lane
`define SER_RATIO 4
`define LANE_COUNT 18
`define WORD_BITS 72
`define WORD_CLKS 8
`define UI_CLKS 2

// Gated occupancy ceiling
`define GATE_LIMIT_UI 1024
`define GATE_LIMIT_WORDS 128
`define GATE_LIMIT (((`GATE_LIMIT_UI / `SER_RATIO) < `GATE_LIMIT_WORDS) ? \
   (`GATE_LIMIT_UI / `SER_RATIO) : `GATE_LIMIT_WORDS)
`define WAKE_MARGIN 4
`define AMBLE_BASE_UI 4

// Link layer register map, byte addresses
`define CTRL_OFS 5'h00
`define DATA0_OFS 5'h04
`define DATA1_OFS 5'h08
`define DATA2_OFS 5'h0C
`define STATUS_OFS 5'h10

// Control fields
`define CTRL_SLEEP 0
`define CTRL_POST_LSB 1
`define CTRL_PRE_LSB 3
`define CTRL_PAY_LSB 5
`define CTRL_RESET 7'h00

`endif

/* clock_gate_pkg.sv */
`default_nettype none
`include "clock_gate_map.svh"

package clock_gate_pkg;
   typedef logic [`WORD_BITS-1:0] word_t;
   typedef enum logic [2:0] {SEND, POST, ASK, GATED, WAKE, PRE} linkState_t;
endpackage

`default_nettype wire

/* clock_gate_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface clock_gate_if (input wire logic clk);
   logic wordStrobe;
   clock_gate_pkg::word_t word;
   logic clockGateRequest;

   modport phy (input word, input clockGateRequest, output wordStrobe);
   modport link (output word, output clockGateRequest, input wordStrobe);
endinterface

`default_nettype wire

/* phy_tx_gate.sv */
`timescale 1ns/1ps
`default_nettype none
`include "clock_gate_map.svh"

module phy_tx_gate (
   input wire logic clk,
   input wire logic rst_n,
   clock_gate_if.phy lnk,
   input wire logic doublyTerminated,
   output logic fwdClkP,
   output logic fwdClkN,
   output logic [`LANE_COUNT-1:0] laneOut,
   output logic rxTermGnd,
   output logic gated,
   output logic [7:0] gatedWords,
   output logic limitExceeded,
   output logic nonIdleWhileGated
);
   localparam int UI_BITS = $clog2(`SER_RATIO);
   localparam logic [7:0] LIMIT = 8'(`GATE_LIMIT);

   logic [2:0] cnt_r, cnt_nxt;
   clock_gate_pkg::word_t word_r, word_nxt;
   logic req_r, req_nxt, gated_r, gated_nxt;
   logic [7:0] gc_r, gc_nxt;
   logic exceed_r, exceed_nxt, dirty_r, dirty_nxt;
   logic fwd_r, fwd_nxt;
   logic [`LANE_COUNT-1:0] lane_r, lane_nxt;
   logic [1:0] term_r, term_nxt;
   logic strobe;

   ////////////////////////////////////////////////////////////////////
   // Word timing and gate control

   assign strobe = (cnt_r == 3'(`WORD_CLKS - 1));
   assign lnk.wordStrobe = strobe;

   always_comb
   begin
      cnt_nxt = cnt_r + 3'h1;
      word_nxt = word_r;
      req_nxt = req_r;
      gated_nxt = gated_r;
      gc_nxt = gc_r;
      exceed_nxt = exceed_r;
      dirty_nxt = dirty_r;
      if (strobe)
      begin
         // Zero words are loaded as ordinary data, never dropped
         word_nxt = lnk.word; // [R3]
         req_nxt = lnk.clockGateRequest; // [R15]
         // Stop and restart lag the request by one word
         gated_nxt = req_r; // [R10] [R11]
         if (gated_r && gc_r != 8'hFF)
            gc_nxt = gc_r + 8'h01; // [R15]
         else if (!gated_r)
            gc_nxt = 8'h00;
         if (gated_nxt && gc_nxt >= LIMIT)
            exceed_nxt = 1'b1; // [R14]
         // Word taken now goes out while gated: must be idle
         if (req_r && |lnk.word)
            dirty_nxt = 1'b1; // [R5] [R12]
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         cnt_r <= 3'h0;
         word_r <= '0;
         req_r <= 1'b0;
         gated_r <= 1'b0;
         gc_r <= 8'h00;
         exceed_r <= 1'b0;
         dirty_r <= 1'b0;
      end
      else
      begin
         cnt_r <= cnt_nxt;
         word_r <= word_nxt;
         req_r <= req_nxt;
         gated_r <= gated_nxt;
         gc_r <= gc_nxt;
         exceed_r <= exceed_nxt;
         dirty_r <= dirty_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Serializer and forwarded clock

   always_comb
   begin
      // Clock rises mid-UI so the far end samples in the eye
      fwd_nxt = !gated_nxt && cnt_nxt[0]; // [R4]
      for (int l = 0; l < `LANE_COUNT; l++)
      begin
         // Power-of-two ratio keeps the bit index a plain slice
         lane_nxt[l] = !gated_nxt &&
            word_nxt[l * `SER_RATIO + int'(cnt_nxt[UI_BITS:1])]; // [R8]
      end
      term_nxt = {term_r[0], doublyTerminated};
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         fwd_r <= 1'b0;
         lane_r <= '0;
         term_r <= 2'b00;
      end
      else
      begin
         fwd_r <= fwd_nxt;
         lane_r <= lane_nxt;
         term_r <= term_nxt;
      end
   end

   assign fwdClkP = fwd_r;
   assign fwdClkN = !fwd_r; // [R4]
   assign laneOut = lane_r;
   // Idle drives 0V, so the termination must sit at ground
   assign rxTermGnd = term_r[1]; // [R2]
   assign gated = gated_r;
   assign gatedWords = gc_r;
   assign limitExceeded = exceed_r;
   assign nonIdleWhileGated = dirty_r;

endmodule

`default_nettype wire

/* forwarded_clock_gating_ctrl_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module forwarded_clock_gating_ctrl_checker (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic wordStrobe,
   input wire clock_gate_pkg::word_t word,
   input wire logic clockGateRequest,
   input wire logic fwdClkP,
   input wire logic fwdClkN,
   input wire logic gated,
   input wire logic [7:0] gatedWords,
   input wire logic limitExceeded,
   input wire logic nonIdleWhileGated,
   input wire logic doublyTerminated,
   input wire logic rxTermGnd
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////
   property p_period;
      wordStrobe |=> !wordStrobe [*7] ##1 wordStrobe;
   endproperty
   a_period: assert property (p_period)
      else $error("strobe spacing wrong");
   property p_enter;
      wordStrobe && clockGateRequest && !gated && !$past(clockGateRequest, 8)
         |=> !gated [*8] ##1 gated;
   endproperty
   a_enter: assert property (p_enter)
      else $error("gating not one word after request");
   property p_leave;
      wordStrobe && !clockGateRequest && gated && $past(clockGateRequest, 8)
         |=> gated [*8] ##1 !gated;
   endproperty
   a_leave: assert property (p_leave)
      else $error("restart not one word after release");
   property p_low;
      gated && $past(gated, 2) |-> !fwdClkP && fwdClkN;
   endproperty
   a_low: assert property (p_low)
      else $error("clock toggles while gated");
   property p_diff;
      fwdClkN == !fwdClkP;
   endproperty
   a_diff: assert property (p_diff)
      else $error("clock pair not complementary");
   property p_gidle;
      gated && wordStrobe |-> word == '0 && !nonIdleWhileGated;
   endproperty
   a_gidle: assert property (p_gidle)
      else $error("data while gated");
   property p_ridle;
      clockGateRequest && wordStrobe |-> word == '0;
   endproperty
   a_ridle: assert property (p_ridle)
      else $error("data while request high");
   property p_limit;
      !limitExceeded && gatedWords <= 8'h80;
   endproperty
   a_limit: assert property (p_limit)
      else $error("gated too long");
   property p_term;
      doublyTerminated [*3] |-> rxTermGnd;
   endproperty
   a_term: assert property (p_term)
      else $error("termination not grounded");
   c_gate: cover property (wordStrobe && gated);
   c_term: cover property (rxTermGnd);
   c_wake: cover property ($fell(gated));
endmodule
`default_nettype wire

/* forwarded_clock_gating_ctrl_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "clock_gate_map.svh"
module forwarded_clock_gating_ctrl_tb_top;
   logic clk, rst_n, doublyTerminated, read, write, waitrequest;
   logic fwdClkP, fwdClkN, rxTermGnd, gated, limitExceeded, nonIdleWhileGated;
   logic [4:0] address;
   logic [31:0] writedata, readdata, q;
   logic [17:0] laneOut, e;
   logic [7:0] gatedWords;
   int error_cnt, n_tests, i;
   clock_gate_if clock_gate_if_i (.clk(clk));
   phy_tx_gate phy_tx_gate_i (.clk(clk), .rst_n(rst_n), .lnk(clock_gate_if_i),
      .doublyTerminated(doublyTerminated), .fwdClkP(fwdClkP), .fwdClkN(fwdClkN),
      .laneOut(laneOut), .rxTermGnd(rxTermGnd), .gated(gated), .gatedWords(gatedWords),
      .limitExceeded(limitExceeded), .nonIdleWhileGated(nonIdleWhileGated));
   link_gate_ctrl link_gate_ctrl_i (.clk(clk), .rst_n(rst_n), .lnk(clock_gate_if_i),
      .address(address), .read(read), .write(write), .writedata(writedata),
      .readdata(readdata), .waitrequest(waitrequest));
   forwarded_clock_gating_ctrl_checker chk_i (.clk(clk), .rst_n(rst_n),
      .wordStrobe(clock_gate_if_i.wordStrobe), .word(clock_gate_if_i.word),
      .clockGateRequest(clock_gate_if_i.clockGateRequest), .fwdClkP(fwdClkP),
      .fwdClkN(fwdClkN), .gated(gated), .gatedWords(gatedWords),
      .limitExceeded(limitExceeded), .nonIdleWhileGated(nonIdleWhileGated),
      .doublyTerminated(doublyTerminated), .rxTermGnd(rxTermGnd));
   ////////////////////////////////////////
   task automatic check(input logic [71:0] seen, input logic [71:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[FAIL] %0t saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      $display("mismatches %0d of %0d", error_cnt, n_tests);
      if (error_cnt == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic timeout(input int k, input int lim);
      if (k >= lim)
      begin
         error_cnt++;
         finish_test();
      end
   endtask
   // Data writes stall until the link takes the word, so allow a long wait
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
      int k;
      @(posedge clk);
      address <= a;
      writedata <= d;
      write <= wr;
      read <= !wr;
      // Held until the edge that sees waitrequest low; data taken there
      for (k = 0; k < 400; k++)
      begin
         @(posedge clk);
         if (waitrequest === 1'b0)
            break;
      end
      timeout(k, 400);
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask
   task automatic wait_gated(input logic lvl);
      int k;
      for (k = 0; k < 1200; k++)
      begin
         @(negedge clk);
         if (gated === lvl)
            break;
      end
      timeout(k, 1200);
   endtask
   ////////////////////////////////////////
   task automatic s_regs();
      bus(0, `CTRL_OFS, 0);
      check(q, 32'h0000_0000);
      bus(1, 5'h14, 32'hFFFF_FFFF);
      bus(0, 5'h14, 0);
      check(q, 32'h0000_0000);
   endtask
   task automatic s_term();
      doublyTerminated <= 1'b1;
      repeat (4) @(posedge clk);
      check(rxTermGnd, 1'b1);
      doublyTerminated <= 1'b0;
   endtask
   // Lane l carries nibble l, first UI is its bit 0
   task automatic s_data(input logic [71:0] w);
      int k;
      bus(1, `DATA0_OFS, w[31:0]);
      bus(1, `DATA1_OFS, w[63:32]);
      bus(1, `DATA2_OFS, {24'h00_0000, w[71:64]});
      for (k = 0; k < 40; k++)
      begin
         @(negedge clk);
         if (clock_gate_if_i.wordStrobe === 1'b1 && clock_gate_if_i.word === w)
            break;
      end
      timeout(k, 40);
      for (k = 0; k < 18; k++)
         e[k] = w[4*k];
      repeat (2) @(posedge clk);
      #1;
      check(laneOut, e);
      repeat (10) @(posedge clk);
      bus(0, `STATUS_OFS, 0);
      check(q[0], 1'b0);
   endtask
   task automatic s_gate(input int n, input logic stay);
      int k, j;
      bus(1, `CTRL_OFS, 32'h1 | (n << 1) | (n << 3) | (n << 5));
      // Padded postamble words before the request word
      k = 0;
      for (j = 0; j < 1200; j++)
      begin
         @(negedge clk);
         if (clock_gate_if_i.clockGateRequest === 1'b1)
            break;
         if (clock_gate_if_i.wordStrobe === 1'b1 &&
            link_gate_ctrl_i.st_r == clock_gate_pkg::POST)
            k++;
      end
      timeout(j, 1200);
      check(k, (1 << n) - 1);
      wait_gated(1'b1);
      repeat (3) @(posedge clk);
      check({fwdClkP, fwdClkN}, 2'b01);
      check(clock_gate_if_i.word, 72'h0);
      bus(0, `STATUS_OFS, 0);
      check(q[1], 1'b1);
      if (!stay)
         bus(1, `CTRL_OFS, 0);
      wait_gated(1'b0);
      check(limitExceeded, 1'b0);
      check(nonIdleWhileGated, 1'b0);
      if (stay)
         bus(1, `CTRL_OFS, 0);
      repeat (40) @(posedge clk);
      // Restarted clock: one high phase per UI, four per word
      k = 0;
      repeat (8)
      begin
         @(negedge clk);
         k += fwdClkP;
      end
      check(k, 4);
   endtask
   ////////////////////////////////////////
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial
   begin
      rst_n = 1'b0;
      doublyTerminated = 1'b0;
      read = 1'b0;
      write = 1'b0;
      address = 5'h00;
      writedata = 32'h0000_0000;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      s_regs();
      s_term();
      s_data(72'hA5_1234_5678_9ABC_DEF0);
      s_data(72'h00_0000_0000_0000_0000);
      for (i = 0; i < 4; i++)
         s_gate(i, 1'b0);
      s_gate(0, 1'b1);
      finish_test();
   end
endmodule
`default_nettype wire
